/* File: verilog/prw_pkg.sv */
package prw_pkg;

    localparam int          DATA_W          = 8;
    localparam int          PADDR_W         = 12;
    localparam int          BLOCK_W         = 6;
    localparam logic [7:0]  BLOCK_SEL_ADDR  = 8'hC9;
    localparam logic [7:0]  WIN_BASE        = 8'h40;
    localparam logic [7:0]  WIN_LAST        = 8'h7F;
    localparam logic [15:0] OPT_DEFAULT     = 16'h0000;
    localparam logic [15:0] OPT_FIXED_MASK  = 16'hFC34;
    localparam logic [15:0] OPT_FIXED_VALUE = 16'h0414;
    localparam int          OPT_EXT_STOP    = 9;
    localparam int          OPT_LVD         = 8;
    localparam int          OPT_PROTECT     = 7;
    localparam int          OPT_OSC_RC      = 6;
    localparam int          OPT_NMI_PULL    = 3;
    localparam int          OPT_WDG_HW      = 1;
    localparam int          OPT_OSG         = 0;

    typedef struct packed {
        logic external_stop_control;
        logic low_voltage_detector_enable;
        logic readout_lock;
        logic osc_rc_network;
        logic nmi_pullup_enable;
        logic watchdog_hardware_mode;
        logic oscillator_guard_enable;
    } prw_options_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } prw_dbus_t;

    typedef enum logic [1:0] {
        PRW_OPT_BLANK   = 2'b00,
        PRW_OPT_BURNT   = 2'b01,
        PRW_OPT_FACTORY = 2'b10
    } prw_opt_state_t;

endpackage

/* File: verilog/prw_rom_window.sv */
`timescale 1ns/10ps
module prw_rom_window #(
    parameter bit          FACTORY_CODED  = 1'b0,
    parameter logic [15:0] FACTORY_OPTION = 16'h0414
) (
    input  wire logic                       ref_clk_i,
    input  wire logic                       rst_n_i,
    input  wire prw_pkg::prw_dbus_t         dbus_i,
    output logic [prw_pkg::DATA_W-1:0]      rdata_o,
    output logic                            rdata_valid_o,
    output logic [prw_pkg::PADDR_W-1:0]     pmem_addr_o,
    output logic                            pmem_rd_o,
    input  wire logic [prw_pkg::DATA_W-1:0] pmem_data_i,
    input  wire logic                       prog_mode_i,
    input  wire logic                       opt_wr_i,
    input  wire logic [15:0]                opt_wdata_i,
    input  wire logic                       opt_rd_i,
    output logic [15:0]                     opt_rdata_o,
    output logic                            opt_wr_err_o,
    input  wire logic                       ext_rd_req_i,
    output logic                            ext_rd_grant_o,
    input  wire logic                       watchdog_active_i,
    input  wire logic                       nmi_pin_i,
    output logic                            stop_allowed_o,
    output prw_pkg::prw_options_t           options_o
);
    import prw_pkg::*;

    logic                 rst_meta_reg;
    logic                 rst_sync_n_reg;
    logic [BLOCK_W-1:0]   block_sel_reg;
    logic [15:0]          opt_reg;
    prw_opt_state_t       opt_state_reg;
    logic                 win_pend_reg;
    logic                 win_hit;
    logic [15:0]          opt_eff;

    // reset release through two flops
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_reg   <= 1'b0;
            rst_sync_n_reg <= 1'b0;
        end else begin
            rst_meta_reg   <= 1'b1;
            rst_sync_n_reg <= rst_meta_reg;
        end
    end

    // no reset here: content is undefined until software writes it
    always_ff @(posedge ref_clk_i) begin
        if (dbus_i.wr && dbus_i.addr == BLOCK_SEL_ADDR) begin
            block_sel_reg <= dbus_i.wdata[BLOCK_W-1:0];
        end
    end

    assign win_hit = dbus_i.rd && dbus_i.addr >= WIN_BASE
                     && dbus_i.addr <= WIN_LAST;

    // block select register itself is never returned on a read
    always_ff @(posedge ref_clk_i or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            pmem_addr_o  <= '0;
            pmem_rd_o    <= 1'b0;
            win_pend_reg <= 1'b0;
        end else begin
            pmem_rd_o    <= win_hit;
            win_pend_reg <= win_hit;
            if (win_hit) begin
                // never taken: BLOCK_SEL_ADDR is outside the window, so a new block is seen from the next cycle
                if (dbus_i.wr && dbus_i.addr == BLOCK_SEL_ADDR) begin
                    pmem_addr_o <= {dbus_i.wdata[BLOCK_W-1:0],
                                    dbus_i.addr[5:0]};
                end else begin
                    pmem_addr_o <= {block_sel_reg, dbus_i.addr[5:0]};
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            rdata_o       <= '0;
            rdata_valid_o <= 1'b0;
        end else begin
            rdata_valid_o <= win_pend_reg;
            if (win_pend_reg) begin
                rdata_o <= pmem_data_i;
            end
        end
    end

    // one-time option store; held through reset like a fuse
    // a case, so that an unknown power-up state still falls to the default
    always_ff @(posedge ref_clk_i) begin
        if (!rst_sync_n_reg) begin
            case (opt_state_reg)
                PRW_OPT_BURNT: begin
                    opt_state_reg <= PRW_OPT_BURNT;
                end
                default: begin
                    opt_state_reg <= FACTORY_CODED ? PRW_OPT_FACTORY
                                                   : PRW_OPT_BLANK;
                    opt_reg       <= OPT_DEFAULT;
                end
            endcase
        end else if (prog_mode_i && opt_wr_i
                     && opt_state_reg == PRW_OPT_BLANK) begin
            opt_reg       <= opt_wdata_i;
            opt_state_reg <= PRW_OPT_BURNT;
        end
    end

    assign opt_eff = (opt_state_reg == PRW_OPT_FACTORY) ? FACTORY_OPTION
                                                        : opt_reg;

    always_ff @(posedge ref_clk_i or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            opt_rdata_o  <= '0;
            opt_wr_err_o <= 1'b0;
        end else begin
            // factory options are never read back on opt_rdata_o
            opt_rdata_o  <= (prog_mode_i && opt_rd_i
                             && opt_state_reg != PRW_OPT_FACTORY)
                            ? opt_reg : 16'h0000;
            // refused burn, or a value breaking the fixed bits
            opt_wr_err_o <= prog_mode_i && opt_wr_i
                            && (opt_state_reg != PRW_OPT_BLANK
                                || (opt_wdata_i & OPT_FIXED_MASK)
                                   != OPT_FIXED_VALUE);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            options_o      <= '0;
            stop_allowed_o <= 1'b0;
            ext_rd_grant_o <= 1'b0;
        end else begin
            options_o.external_stop_control       <= opt_eff[OPT_EXT_STOP];
            options_o.low_voltage_detector_enable <= opt_eff[OPT_LVD];
            options_o.readout_lock                <= opt_eff[OPT_PROTECT];
            options_o.osc_rc_network              <= opt_eff[OPT_OSC_RC];
            options_o.nmi_pullup_enable           <= opt_eff[OPT_NMI_PULL];
            options_o.watchdog_hardware_mode      <= opt_eff[OPT_WDG_HW];
            options_o.oscillator_guard_enable     <= opt_eff[OPT_OSG];
            // option levels drive their consumers directly
            stop_allowed_o <= !watchdog_active_i
                              || (opt_eff[OPT_EXT_STOP] && nmi_pin_i);
            ext_rd_grant_o <= ext_rd_req_i && !opt_eff[OPT_PROTECT];
        end
    end

endmodule // prw_rom_window

/* File: verification/prw_rom_window_assertions.sv */
`timescale 1ns/10ps
module prw_rom_window_assertions
    import prw_pkg::*;
(
    input  wire logic          ref_clk_i,
    input  wire logic          rst_n_i,
    input  wire prw_dbus_t     dbus_i,
    input  wire logic [7:0]    rdata_o,
    input  wire logic          rdata_valid_o,
    input  wire logic [11:0]   pmem_addr_o,
    input  wire logic          pmem_rd_o,
    input  wire logic [7:0]    pmem_data_i,
    input  wire logic          prog_mode_i,
    input  wire logic          opt_wr_i,
    input  wire logic          opt_rd_i,
    input  wire logic [15:0]   opt_rdata_o,
    input  wire logic          opt_wr_err_o,
    input  wire logic          ext_rd_req_i,
    input  wire logic          ext_rd_grant_o,
    input  wire logic          watchdog_active_i,
    input  wire logic          nmi_pin_i,
    input  wire logic          stop_allowed_o,
    input  wire prw_options_t  options_o
);
    logic [5:0] blk;
    wire        win;
    assign win = dbus_i.rd && dbus_i.addr >= WIN_BASE
                 && dbus_i.addr <= WIN_LAST;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // block select survives reset, so this copy is not reset either
    always_ff @(posedge ref_clk_i)
        if (dbus_i.wr && dbus_i.addr == BLOCK_SEL_ADDR)
            blk <= dbus_i.wdata[5:0];
    a_win_strobe: assert property (win |=> pmem_rd_o)
        else $error("window read raised no memory strobe");
    a_win_addr: assert property (
        win |=> pmem_addr_o == {blk, $past(dbus_i.addr[5:0])})
        else $error("window address is not block plus offset");
    a_no_stray: assert property (dbus_i.rd && !win |=> !pmem_rd_o)
        else $error("read outside the window reached memory");
    a_data_path: assert property (
        pmem_rd_o |=> rdata_valid_o && rdata_o == $past(pmem_data_i))
        else $error("window data not returned after memory strobe");
    a_valid_cause: assert property (rdata_valid_o |-> $past(pmem_rd_o))
        else $error("read data valid without a memory strobe");
    a_opt_hidden: assert property (
        !(opt_rd_i && prog_mode_i) |=> opt_rdata_o == 16'h0000)
        else $error("option value visible outside programming mode");
    a_lock_grant: assert property (
        options_o.readout_lock |-> !ext_rd_grant_o)
        else $error("external readout granted while locked");
    a_stop_block: assert property (
        watchdog_active_i && !nmi_pin_i |=> !stop_allowed_o)
        else $error("stop allowed with watchdog active and pin low");
    a_err_cause: assert property (
        opt_wr_err_o |-> $past(opt_wr_i && prog_mode_i))
        else $error("option error without a programming write");
    c_win: cover property (win ##2 rdata_valid_o);
    c_err: cover property (opt_wr_err_o);
    c_grant: cover property (ext_rd_grant_o);
    c_stop: cover property (watchdog_active_i && stop_allowed_o);
endmodule // prw_rom_window_assertions

/* File: verification/prw_pmem_model.sv */
`timescale 1ns/10ps
module prw_pmem_model (
    input  wire logic [11:0] addr_i,
    input  wire logic        rd_i,
    output logic [7:0]       data_o
);
    logic [7:0] val;
    assign val = addr_i[7:0] ^ {4'h0, addr_i[11:8]} ^ 8'h5A;
    // outside the strobe the byte is not held, so show its inverse
    assign data_o = rd_i ? val : ~val;
endmodule // prw_pmem_model

/* File: verification/prw_rom_window_bench.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module prw_rom_window_bench;
    import prw_pkg::*;
    logic ref_clk_i = 0, rst_n_i = 0, prog_mode_i = 0, opt_wr_i = 0;
    logic opt_rd_i = 0, ext_rd_req_i = 0, watchdog_active_i = 0, nmi_pin_i = 0;
    logic [15:0] opt_wdata_i = 0, opt_rdata_o, v;
    logic [11:0] pmem_addr_o;
    logic [7:0] rdata_o, pmem_data_i, e;
    logic [5:0] blk;
    logic rdata_valid_o, pmem_rd_o, opt_wr_err_o, ext_rd_grant_o, stop_allowed_o;
    prw_dbus_t dbus_i = '0;
    prw_options_t options_o;
    logic [7:0] q[$];
    int err_total = 0, cmp_count = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    prw_rom_window prw_rom_window_inst (.*);
    prw_pmem_model prw_pmem_model_inst (.addr_i(pmem_addr_o), .rd_i(pmem_rd_o),
                                        .data_o(pmem_data_i));
    task automatic close_out;
        if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic bus(input logic w, r, input logic [7:0] a, d);
        @(posedge ref_clk_i);
        #1 dbus_i = '{w, r, a, d};
        if (w && a == BLOCK_SEL_ADDR) blk = d[5:0];
        if (r && a >= WIN_BASE && a <= WIN_LAST)
            q.push_back({blk[1:0], a[5:0]} ^ {4'h0, blk[5:2]} ^ 8'h5A);
    endtask
    task automatic opt(input logic pm, w, r, input logic [15:0] d);
        @(posedge ref_clk_i);
        #1 {prog_mode_i, opt_wr_i, opt_rd_i, opt_wdata_i} = {pm, w, r, d};
    endtask
    // sampled mid-cycle, away from the edge that launches the result
    always @(negedge ref_clk_i)
        if (rdata_valid_o === 1'b1) begin
            e = q.size() ? q.pop_front() : ~rdata_o;
            `CHK(rdata_o, e)
        end
    initial begin
        void'($urandom(92));
        repeat (8) @(posedge ref_clk_i);
        #1 rst_n_i = 1;
        repeat (3) bus(0, 0, 8'h00, 8'h00);
        // every block, reserved top bits random, read right after the write
        for (int i = 0; i < 64; i++) begin
            bus(1, 0, BLOCK_SEL_ADDR, {2'($urandom), 6'(i)});
            bus(0, 1, WIN_BASE, 8'h00);
            bus(0, 1, {2'b01, 6'($urandom)}, 8'h00);
            bus(0, 1, WIN_LAST, 8'h00);
            bus(0, 1, 8'h3F, 8'h00);
            bus(0, 1, 8'h80, 8'h00);
        end
        repeat (3) bus(0, 0, 8'h00, 8'h00);
        `CHK(q.size(), 0)
        ext_rd_req_i = 1;
        opt(1, 0, 1, 0);
        opt(1, 0, 1, 0);
        `CHK(opt_rdata_o, OPT_DEFAULT)
        `CHK(ext_rd_grant_o, 1'b1)
        `CHK(stop_allowed_o, 1'b1)
        v = OPT_FIXED_VALUE | (16'($urandom) & ~OPT_FIXED_MASK)
            | 16'h0282;
        opt(0, 1, 0, 16'hFFFF);
        opt(1, 0, 1, 0);
        opt(1, 0, 1, 0);
        `CHK(opt_rdata_o, OPT_DEFAULT)
        opt(1, 1, 0, v);
        opt(1, 0, 0, 0);
        `CHK(opt_wr_err_o, 1'b0)
        opt(1, 1, 0, ~v);
        opt(1, 0, 1, 0);
        `CHK(opt_wr_err_o, 1'b1)
        opt(1, 0, 1, 0);
        `CHK(opt_rdata_o, v)
        opt(0, 0, 1, 0);
        opt(0, 0, 0, 0);
        `CHK(opt_rdata_o, 16'h0000)
        {watchdog_active_i, nmi_pin_i} = 2'b11;
        repeat (3) opt(0, 0, 0, 0);
        `CHK(options_o, prw_options_t'({v[9:6], v[3], v[1:0]}))
        `CHK(ext_rd_grant_o, 1'b0)
        `CHK(stop_allowed_o, 1'b1)
        nmi_pin_i = 0;
        repeat (2) opt(0, 0, 0, 0);
        `CHK(stop_allowed_o, 1'b0)
        close_out;
    end
    initial begin
        #20000 err_total++;
        close_out;
    end
endmodule // prw_rom_window_bench
bind prw_rom_window prw_rom_window_assertions prw_rom_window_assertions_inst (.*);
